// >>> drms_mode_selector.sv
// Loop mode and input reference selection with failure masks
`timescale 1ns/1ns
// Summary of operation
// - Mode field picks freerun 00, forced holdover 01, forced lock 10, automatic 11.
// - Automatic mode chooses by availability and priority, holding over only with none left.
// - Forced lock tracks only the programmed reference and holds over if it fails.
// - Forced holdover ignores all references and keeps the last selected one.
// - Freerun uses only the crystal oscillator input.
// - Feedback enable set applies external feedback phase to all outputs, clear ignores it.
// - The one shared feedback input is used by any loop whose enable is set.
// - In automatic mode the reference field reads back the selected reference index.
// - In forced lock mode the reference field selects the forced reference 0 to 3.
// - In freerun and forced holdover the reference field is ignored.
// - A low holdover mask bit stops holdover entry for that failure type.
// - Holdover mask bits are loss of signal, single cycle, coarse frequency, guard soak.
// - A low switch mask bit stops a reference switch caused by that failure type.
// - Switch mask bits follow the same failure order as the holdover mask.
// - Automatic mode reverts to a better priority but not among equal priorities.
module drms_mode_selector #(
   parameter int NREF = 4
)(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Register port
   input wire logic reg_sel_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   // Failure monitors, one bit per reference per type
   input wire logic [NREF-1:0] loss_of_signal_fail_i,
   input wire logic [NREF-1:0] single_cycle_monitor_fail_i,
   input wire logic [NREF-1:0] coarse_frequency_monitor_fail_i,
   input wire logic [NREF-1:0] guard_soak_timer_fail_i,
   // Reference priorities, 3 bits each, 7 disables
   input wire logic [3*NREF-1:0] ref_priority_i,
   // Shared external feedback phase
   input wire logic [15:0] ext_fb_phase_i,
   // Loop control outputs
   output logic [1:0] ref_index_o,
   output logic ref_track_o,
   output logic holdover_o,
   output logic freerun_o,
   output logic use_ext_fb_o,
   output logic [15:0] fb_phase_o,
   output logic [3:0] state_o
);
   logic [1:0] loop_mode_field_r;
   logic [2:0] mode_rsvd_r;
   logic external_feedback_enable_r;
   logic [1:0] reference_select_or_status_r;
   logic [3:0] holdover_failure_mask_r;
   logic [3:0] switch_failure_mask_r;
   logic [1:0] sel_ref_r;
   logic sel_valid_r;
   drms_pkg::drms_state_t state_r;
   drms_pkg::drms_state_t state_nxt;
   logic [1:0] sel_ref_nxt;
   logic sel_valid_nxt;
   logic [NREF-1:0] ho_fail;
   logic [NREF-1:0] sw_fail;
   logic [NREF-1:0] avail;
   logic [1:0] pick;
   logic any_avail;
   logic [15:0] fb_phase_r;
   logic use_fb_r;

   // Fold the four failure types through a mask; monitors come in as arguments
   // so that the assignments below follow every change of a failure level
   function automatic logic [NREF-1:0] masked_fail(input logic [3:0] mask,
                                                   input logic [NREF-1:0] loss_of_signal_fail,
                                                   input logic [NREF-1:0] single_cycle_monitor_fail,
                                                   input logic [NREF-1:0] coarse_frequency_monitor_fail,
                                                   input logic [NREF-1:0] guard_soak_timer_fail);
      masked_fail = ({NREF{mask[drms_pkg::FAIL_LOS]}} & loss_of_signal_fail)
                  | ({NREF{mask[drms_pkg::FAIL_SCM]}} & single_cycle_monitor_fail)
                  | ({NREF{mask[drms_pkg::FAIL_CFM]}} & coarse_frequency_monitor_fail)
                  | ({NREF{mask[drms_pkg::FAIL_GST]}} & guard_soak_timer_fail);
   endfunction

   assign ho_fail = masked_fail(holdover_failure_mask_r, loss_of_signal_fail_i,
                                single_cycle_monitor_fail_i, coarse_frequency_monitor_fail_i,
                                guard_soak_timer_fail_i);
   assign sw_fail = masked_fail(switch_failure_mask_r, loss_of_signal_fail_i,
                                single_cycle_monitor_fail_i, coarse_frequency_monitor_fail_i,
                                guard_soak_timer_fail_i);
   // A reference is a switch candidate unless an unmasked failure stands on it
   assign avail = ~sw_fail;

   drms_ref_chooser #(
      .NREF(NREF)
   ) u_chooser (
      .avail_i(avail),
      .prio_i(ref_priority_i),
      .cur_i(sel_ref_r),
      .cur_valid_i(sel_valid_r && state_r == drms_pkg::ST_LOCKED),
      .pick_o(pick),
      .any_o(any_avail)
   );

   // Register writes
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         loop_mode_field_r <= drms_pkg::MODE_REG_RST[1:0];
         mode_rsvd_r <= drms_pkg::RSVD_MODE_RST;
         external_feedback_enable_r <= drms_pkg::MODE_REG_RST[5];
         reference_select_or_status_r <= drms_pkg::MODE_REG_RST[7:6];
         holdover_failure_mask_r <= drms_pkg::MASK_REG_RST[3:0];
         switch_failure_mask_r <= drms_pkg::MASK_REG_RST[7:4];
      end
      else if (reg_wr_i)
      begin
         if (reg_sel_i == drms_pkg::MODE_REG_SEL)
         begin
            loop_mode_field_r <= reg_wdata_i[drms_pkg::MODE_LSB +: 2];
            mode_rsvd_r <= reg_wdata_i[4:2];
            external_feedback_enable_r <= reg_wdata_i[drms_pkg::FB_EN_BIT];
            // Field write is dropped while automatic mode stays in force
            if (!(loop_mode_field_r == drms_pkg::MODE_AUTO
                  && reg_wdata_i[1:0] == drms_pkg::MODE_AUTO))
            begin
               reference_select_or_status_r <= reg_wdata_i[drms_pkg::REFSEL_LSB +: 2];
            end
         end
         else
         begin
            holdover_failure_mask_r <= reg_wdata_i[drms_pkg::HO_MASK_LSB +: 4];
            switch_failure_mask_r <= reg_wdata_i[drms_pkg::SW_MASK_LSB +: 4];
         end
      end
   end

   // Register reads; automatic mode shows the live selection
   always_comb
   begin
      if (reg_sel_i == drms_pkg::MODE_REG_SEL)
      begin
         reg_rdata_o = {reference_select_or_status_r, external_feedback_enable_r,
                        mode_rsvd_r, loop_mode_field_r};
         if (loop_mode_field_r == drms_pkg::MODE_AUTO)
         begin
            reg_rdata_o[7:6] = sel_ref_r;
         end
      end
      else
      begin
         reg_rdata_o = {switch_failure_mask_r, holdover_failure_mask_r};
      end
   end

   // Next state and reference choice
   always_comb
   begin
      state_nxt = state_r;
      sel_ref_nxt = sel_ref_r;
      sel_valid_nxt = sel_valid_r;
      unique case (loop_mode_field_r)
         drms_pkg::MODE_FREERUN:
         begin
            state_nxt = drms_pkg::ST_FREERUN;
         end
         drms_pkg::MODE_HOLDOVER:
         begin
            // Keep last selected reference as the holdover basis
            state_nxt = sel_valid_r ? drms_pkg::ST_HOLDOVER : drms_pkg::ST_FREERUN;
         end
         drms_pkg::MODE_FORCED:
         begin
            sel_ref_nxt = reference_select_or_status_r;
            sel_valid_nxt = 1'b1;
            // Failure masked for holdover keeps the loop on the forced reference
            if (ho_fail[reference_select_or_status_r])
            begin
               state_nxt = drms_pkg::ST_HOLDOVER;
            end
            else
            begin
               state_nxt = drms_pkg::ST_LOCKED;
            end
         end
         drms_pkg::MODE_AUTO:
         begin
            if (any_avail)
            begin
               sel_ref_nxt = pick;
               sel_valid_nxt = 1'b1;
               state_nxt = drms_pkg::ST_LOCKED;
            end
            else if (sel_valid_r && !ho_fail[sel_ref_r])
            begin
               state_nxt = drms_pkg::ST_LOCKED;
            end
            else
            begin
               state_nxt = sel_valid_r ? drms_pkg::ST_HOLDOVER : drms_pkg::ST_FREERUN;
            end
         end
      endcase
   end

   // Loop state
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         state_r <= drms_pkg::ST_FREERUN;
         sel_ref_r <= 2'h0;
         sel_valid_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         sel_ref_r <= sel_ref_nxt;
         sel_valid_r <= sel_valid_nxt;
      end
   end

   // Shared external feedback, taken whenever the enable is set
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         fb_phase_r <= 16'h0000;
         use_fb_r <= 1'b0;
      end
      else
      begin
         use_fb_r <= external_feedback_enable_r;
         fb_phase_r <= external_feedback_enable_r ? ext_fb_phase_i : 16'h0000;
      end
   end

   assign ref_index_o = sel_ref_r;
   assign ref_track_o = state_r == drms_pkg::ST_LOCKED;
   assign holdover_o = state_r == drms_pkg::ST_HOLDOVER;
   assign freerun_o = state_r == drms_pkg::ST_FREERUN;
   assign use_ext_fb_o = use_fb_r;
   assign fb_phase_o = fb_phase_r;
   assign state_o = state_r;
endmodule

// >>> drms_pkg.sv
// Package with register layout, reset values and encodings for the reference mode selector
package drms_pkg;
   // Loop mode encodings
   localparam logic [1:0] MODE_FREERUN = 2'h0;
   localparam logic [1:0] MODE_HOLDOVER = 2'h1;
   localparam logic [1:0] MODE_FORCED = 2'h2;
   localparam logic [1:0] MODE_AUTO = 2'h3;
   // Register select codes on the register port
   localparam logic MODE_REG_SEL = 1'h0;
   localparam logic MASK_REG_SEL = 1'h1;
   // Reset values
   localparam logic [7:0] MODE_REG_RST = 8'h0F;
   localparam logic [7:0] MASK_REG_RST = 8'h87;
   // Field positions in loop_mode_reference_select
   localparam int MODE_LSB = 0;
   localparam int FB_EN_BIT = 5;
   localparam int REFSEL_LSB = 6;
   localparam logic [2:0] RSVD_MODE_RST = 3'h3;
   // Field positions in reference_failure_masks
   localparam int HO_MASK_LSB = 0;
   localparam int SW_MASK_LSB = 4;
   // Failure type bit order
   localparam int FAIL_LOS = 0;
   localparam int FAIL_SCM = 1;
   localparam int FAIL_CFM = 2;
   localparam int FAIL_GST = 3;
   // Priority number meaning disabled
   localparam logic [2:0] PRIO_DISABLED = 3'h7;
   // Loop states, one-hot
   typedef enum logic [3:0] {
      ST_FREERUN = 4'h1,
      ST_LOCKED = 4'h2,
      ST_HOLDOVER = 4'h4,
      ST_SELECT = 4'h8
   } drms_state_t;
endpackage

// >>> drms_ref_chooser.sv
// Priority chooser: picks the best available reference with non-revertive ties
`timescale 1ns/1ns
module drms_ref_chooser #(
   parameter int NREF = 4
)(
   // Candidates
   input wire logic [NREF-1:0] avail_i,
   input wire logic [3*NREF-1:0] prio_i,
   // Current choice
   input wire logic [1:0] cur_i,
   input wire logic cur_valid_i,
   // Result
   output logic [1:0] pick_o,
   output logic any_o
);
   logic [2:0] best;
   always_comb
   begin
      best = drms_pkg::PRIO_DISABLED;
      pick_o = 2'h0;
      any_o = 1'b0;
      // Strictly lower number wins; lowest index breaks first ties
      for (int i = 0; i < NREF; i++)
      begin
         if (avail_i[i] && prio_i[3*i +: 3] != drms_pkg::PRIO_DISABLED
             && (!any_o || prio_i[3*i +: 3] < best))
         begin
            best = prio_i[3*i +: 3];
            pick_o = 2'(i);
            any_o = 1'b1;
         end
      end
      // Keep current reference when an equal priority is all that competes
      if (cur_valid_i && avail_i[cur_i] && any_o && prio_i[3*cur_i +: 3] == best)
      begin
         pick_o = cur_i;
      end
   end
endmodule

// >>> drms_checker.sv
// Concurrent checks on the mode selector ports
`timescale 1ns/1ns
module drms_checker #(
   parameter int NREF = 4
)(
   // Clock, reset and register port
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic reg_sel_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   // Monitors and feedback
   input wire logic [NREF-1:0] loss_of_signal_fail_i,
   input wire logic [NREF-1:0] single_cycle_monitor_fail_i,
   input wire logic [NREF-1:0] coarse_frequency_monitor_fail_i,
   input wire logic [NREF-1:0] guard_soak_timer_fail_i,
   input wire logic [3*NREF-1:0] ref_priority_i,
   input wire logic [15:0] ext_fb_phase_i,
   // Loop outputs
   input wire logic [1:0] ref_index_o,
   input wire logic ref_track_o,
   input wire logic holdover_o,
   input wire logic freerun_o,
   input wire logic use_ext_fb_o,
   input wire logic [15:0] fb_phase_o,
   input wire logic [3:0] state_o
);
   logic [7:0] mode_r;
   logic [7:0] mask_r;
   logic [3:0] fl [4];
   logic [3:0] avail;
   logic ho_fail;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // Shadow copies of both registers; status bits are not stored while in auto
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         mode_r <= drms_pkg::MODE_REG_RST;
      else if (reg_wr_i && !reg_sel_i)
         mode_r <= (mode_r[1:0] == 2'h3 && reg_wdata_i[1:0] == 2'h3) ?
            {mode_r[7:6], reg_wdata_i[5:0]} : reg_wdata_i;
   end
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         mask_r <= drms_pkg::MASK_REG_RST;
      else if (reg_wr_i && reg_sel_i)
         mask_r <= reg_wdata_i;
   end
   always_comb
   begin
      for (int r = 0; r < 4; r++)
      begin
         fl[r] = {guard_soak_timer_fail_i[r], coarse_frequency_monitor_fail_i[r],
            single_cycle_monitor_fail_i[r], loss_of_signal_fail_i[r]};
         avail[r] = !(|(fl[r] & mask_r[7:4])) && ref_priority_i[3*r +: 3] != 3'h7;
      end
      ho_fail = |(fl[mode_r[7:6]] & mask_r[3:0]);
   end
   a_freerun_mode: assert property (mode_r[1:0] == 2'h0 |=> freerun_o && !ref_track_o)
      else $error("freerun mode not entered");
   a_forced_hold: assert property (mode_r[1:0] == 2'h1 |=> !ref_track_o)
      else $error("forced holdover still tracks");
   a_forced_track: assert property (mode_r[1:0] == 2'h2 && !ho_fail |=>
      ref_track_o && ref_index_o == $past(mode_r[7:6])) else $error("forced ref not tracked");
   a_forced_fail: assert property (mode_r[1:0] == 2'h2 && ho_fail |=> holdover_o)
      else $error("failed forced ref without holdover");
   a_auto_lock: assert property (mode_r[1:0] == 2'h3 && avail != 4'h0 |=> ref_track_o)
      else $error("auto mode not locked with a ref available");
   a_fb_enable: assert property (1'b1 |=> use_ext_fb_o == $past(mode_r[5]))
      else $error("feedback enable not followed");
   a_fb_phase: assert property (1'b1 |=>
      fb_phase_o == ($past(mode_r[5]) ? $past(ext_fb_phase_i) : 16'h0000))
      else $error("feedback phase wrong");
   a_mode_read: assert property (!reg_sel_i |-> reg_rdata_o ==
      ((mode_r[1:0] == 2'h3) ? {ref_index_o, mode_r[5:0]} : mode_r))
      else $error("mode register read wrong");
   a_mask_read: assert property (reg_sel_i |-> reg_rdata_o == mask_r)
      else $error("mask register read wrong");
   a_state_code: assert property (state_o == {1'b0, holdover_o, ref_track_o, freerun_o})
      else $error("state code and flags disagree");
   c_forced_fail: cover property (mode_r[1:0] == 2'h2 && ho_fail ##1 holdover_o);
   c_auto_switch: cover property (mode_r[1:0] == 2'h3 && $changed(ref_index_o));
   c_fb_on: cover property ($rose(use_ext_fb_o));
endmodule
bind drms_mode_selector drms_checker #(.NREF(NREF)) drms_checker_i (.*);

// >>> drms_ref_monitor.sv
// Reference failure monitor model driving per-type failure levels
`timescale 1ns/1ns
module drms_ref_monitor (
   // Clock and requested pattern, one nibble per failure type
   input wire logic clk_i,
   input wire logic [15:0] fail_set_i,
   // Failure levels, high means failed
   output logic [3:0] loss_fail_o,
   output logic [3:0] cycle_fail_o,
   output logic [3:0] freq_fail_o,
   output logic [3:0] soak_fail_o
);
   // A monitor needs a cycle to decide, so levels lag the request
   always_ff @(posedge clk_i)
   begin
      {soak_fail_o, freq_fail_o, cycle_fail_o, loss_fail_o} <= fail_set_i;
   end
endmodule

// >>> test_dpll_reference_mode_selector.sv
// Testbench for the loop mode and reference selector
`timescale 1ns/1ns
module test_dpll_reference_mode_selector;
   localparam logic [3:0] TRK = 4'h8;
   localparam logic [3:0] HLD = 4'h4;
   localparam logic [3:0] FRE = 4'h2;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic reg_sel_i = 1'b0;
   logic reg_wr_i = 1'b0;
   logic [7:0] reg_wdata_i = 8'h00;
   logic [15:0] fail_set = 16'h0000;
   logic [11:0] ref_priority_i = 12'h000;
   logic [15:0] ext_fb_phase_i = 16'h0000;
   logic [3:0] loss_f, cyc_f, frq_f, soak_f, state_o;
   logic [7:0] reg_rdata_o, g;
   logic [1:0] ref_index_o, rsel;
   logic ref_track_o, holdover_o, freerun_o, use_ext_fb_o;
   logic [15:0] fb_phase_o;
   logic [9:0] q[$];
   logic [9:0] n;
   event chk_ev;
   int errors = 0;
   int total_checks = 0;
   always #5 clk_i = ~clk_i;
   drms_ref_monitor drms_ref_monitor_i (.clk_i(clk_i), .fail_set_i(fail_set),
      .loss_fail_o(loss_f), .cycle_fail_o(cyc_f), .freq_fail_o(frq_f), .soak_fail_o(soak_f));
   drms_mode_selector drms_mode_selector_i (.clk_i(clk_i), .rstn_i(rstn_i),
      .reg_sel_i(reg_sel_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
      .reg_rdata_o(reg_rdata_o), .loss_of_signal_fail_i(loss_f),
      .single_cycle_monitor_fail_i(cyc_f), .coarse_frequency_monitor_fail_i(frq_f),
      .guard_soak_timer_fail_i(soak_f), .ref_priority_i(ref_priority_i),
      .ext_fb_phase_i(ext_fb_phase_i), .ref_index_o(ref_index_o), .ref_track_o(ref_track_o),
      .holdover_o(holdover_o), .freerun_o(freerun_o), .use_ext_fb_o(use_ext_fb_o),
      .fb_phase_o(fb_phase_o), .state_o(state_o));
   task automatic compare(input logic [7:0] got, input logic [7:0] exp, input string what);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // Oldest note against what the outputs show now
   always @(chk_ev)
   begin
      n = q.pop_front();
      g = {2'h0, ref_index_o, ref_track_o, holdover_o, freerun_o, use_ext_fb_o};
      if (n[9])
         g[5:4] = n[5:4];
      if (n[8])
         compare(reg_rdata_o, n[7:0], "register read");
      else
         compare(g, n[7:0], "loop state");
   end
   task automatic wr(input logic sel, input logic [7:0] d);
      @(negedge clk_i);
      reg_sel_i = sel;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      @(negedge clk_i);
      reg_wr_i = 1'b0;
   endtask
   // Monitor lag plus state update fit in three cycles
   task automatic st(input logic [3:0] e, input logic [1:0] idx, input logic anyidx);
      repeat (3) @(negedge clk_i);
      q.push_back({anyidx, 1'b0, 2'h0, idx, e});
      -> chk_ev;
   endtask
   task automatic rd(input logic sel, input logic [7:0] e);
      @(negedge clk_i);
      reg_sel_i = sel;
      #1;
      q.push_back({2'b01, e});
      -> chk_ev;
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      #50000;
      errors++;
      results();
   end
   initial
   begin
      void'($urandom(32'hE1F21F61));
      repeat (3) @(negedge clk_i);
      rstn_i = 1'b1;
      rd(1'b0, drms_pkg::MODE_REG_RST);
      rd(1'b1, drms_pkg::MASK_REG_RST);
      st(TRK, 2'h0, 1'b0);
      $display("reset defaults done");
      for (int r = 0; r < 4; r++)
      begin
         wr(1'b0, {r[1:0], 6'h02});
         st(TRK, r[1:0], 1'b0);
      end
      wr(1'b0, 8'h01);
      st(HLD, 2'h0, 1'b1);
      wr(1'b0, 8'hC0);
      st(FRE, 2'h0, 1'b1);
      ext_fb_phase_i = 16'($urandom);
      wr(1'b0, 8'hA1);
      st(HLD | 4'h1, 2'h0, 1'b1);
      $display("mode selection done");
      for (int t = 0; t < 4; t++)
      begin
         rsel = 2'($urandom_range(3));
         wr(1'b1, {4'h8, ~(4'h1 << t)});
         wr(1'b0, {rsel, 6'h02});
         fail_set = 16'h0001 << (4 * t + rsel);
         st(TRK, rsel, 1'b0);
         fail_set = 16'h0001 << (4 * ((t + 1) % 4) + rsel);
         st(HLD, 2'h0, 1'b1);
         fail_set = 16'h0000;
      end
      $display("holdover masks done");
      ref_priority_i = 12'h688;
      wr(1'b0, 8'h03);
      for (int t = 0; t < 4; t++)
      begin
         wr(1'b1, {~(4'h1 << t), 4'h7});
         fail_set = 16'h0001 << (4 * t);
         st(TRK, 2'h0, 1'b0);
         fail_set = 16'h0001 << (4 * ((t + 1) % 4));
         st(TRK, 2'h1, 1'b0);
         fail_set = 16'h0000;
         st(TRK, 2'h0, 1'b0);
      end
      ref_priority_i = 12'hFC9;
      wr(1'b1, 8'hF7);
      fail_set = 16'h0001;
      st(TRK, 2'h1, 1'b0);
      fail_set = 16'h0000;
      st(TRK, 2'h1, 1'b0);
      wr(1'b0, 8'h03);
      rd(1'b0, 8'h43);
      fail_set = 16'h0003;
      st(HLD, 2'h0, 1'b1);
      $display("automatic switching done");
      results();
   end
endmodule
